// ===== core/gcwtp_pkg.sv
// Purpose: Constants for the twelve-pin I/O controller with timestamp pins
// Assumes: 250 MHz system clock; word-aligned byte addresses on the reg port
// Notes: Pins 9 and 8 are the timestamp pins; index 1 is pin 9, 0 is pin 8
// Contract
// - Reset clears all twelve direction bits
// - Reset clears every pin interrupt enable
// - Reset clears interrupt polarity, low-level triggering
// - Output pins use push-pull or open-drain per bit
// - Open-drain drives low on 0, floats on 1
// - Outputs drive data bit; inputs read pin
// - Timestamp output enable forces pins 9,8 output
// - Timestamp output enable keeps buffer type selection
// - Input edge captures time, sets both flags
// - Enabled input edge clears target flag
// - Edge counts only if active over 40 ns
// - Compare event when target equals time value
// - Compare event pulses, toggles or mirrors flag
// - Compare output polarity per event polarity bit
// - Pin status readable, honoured only when enabled
// - Enabled pin interrupts summed onto one line
// - Polarity bit selects high or low level
// - Interrupt polarity also governs pins 9,8 events
// - Capture flags each gated by own enable
// - Pins 7..0 may be indicators, straps default
// - Time equals target sets target flag
// - Timestamp flags ANDed with enables, ORed
package gcwtp_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_DATA_DIR = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_INT_POL = 8'h08;
    localparam logic [7:0] ADDR_PIN_INT = 8'h0c;
    localparam logic [7:0] ADDR_TS_INT = 8'h10;
    localparam logic [7:0] ADDR_TS_CFG = 8'h14;
    localparam logic [7:0] ADDR_TGT_LO = 8'h18;
    localparam logic [7:0] ADDR_TGT_HI = 8'h1c;
    localparam logic [7:0] ADDR_CAP8_LO = 8'h20;
    localparam logic [7:0] ADDR_CAP8_HI = 8'h24;
    localparam logic [7:0] ADDR_CAP9_LO = 8'h28;
    localparam logic [7:0] ADDR_CAP9_HI = 8'h2c;
    localparam logic [7:0] ADDR_LED_CFG = 8'h30;
    // Field positions
    localparam int DIR_POS = 16;
    localparam int EN_POS = 16;
    localparam int TSOE_POS = 12;
    localparam int TCLR_POS = 14;
    localparam int CPOL_POS = 16;
    localparam int TS_TGT = 0;
    localparam int TS_CAP8 = 1;
    localparam int TS_CAP9 = 2;
    // Reset values
    localparam logic [11:0] RST_ZERO12 = 12'h000;
    localparam logic [63:0] RST_ZERO64 = 64'h0;
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int MIN_ACTIVE_NS = 40;
    localparam int PULSE_NS = 100;
    // Strictly longer than the least width: one cycle beyond the round-up
    localparam int FILT_CYC = (MIN_ACTIVE_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS + 1;
    localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        GCWTP_EV_PULSE = 2'b00,
        GCWTP_EV_TOGGLE = 2'b01,
        GCWTP_EV_MIRROR = 2'b10,
        GCWTP_EV_OFF = 2'b11
    } gcwtp_event_sel_t;
endpackage : gcwtp_pkg

// ===== core/gcwtp_top.sv
// Purpose: Twelve-pin I/O controller with timestamp capture and compare pins
// Assumes: Pin and bus inputs synchronous enough to sample; time_value_in
//          advances in the system clock domain
// Notes: Pin drive is output, output enable and input per pin, all registered
`timescale 1ns/100ps
module gcwtp_top #(
    parameter int NPIN = 12
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe_out,
    input wire logic [63:0] time_value_in,
    input wire logic [7:0] indicator_enable_straps_in,
    input wire logic [7:0] indicator_level_in,
    output logic pin_irq_out,
    output logic timestamp_event_summary_out
);
    logic [NPIN-1:0] pin_data_bits_r;
    logic [NPIN-1:0] pin_direction_bits_r;
    logic [NPIN-1:0] output_buffer_type_bits_r;
    logic [NPIN-1:0] interrupt_polarity_bits_r;
    logic [NPIN-1:0] pin_top_interrupt_status_r;
    logic [NPIN-1:0] pin_int_en_r;
    logic [1:0] ts_oe_r;
    logic [1:0] tgt_clr_en_r;
    logic [1:0] compare_polarity_r;
    logic [1:0] event_sel_r [2];
    logic [2:0] ts_flags_r;
    logic [2:0] ts_en_r;
    logic [63:0] target_r;
    logic [63:0] capture_r [2];
    logic [7:0] led_en_r;
    logic strap_done_r;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    logic [3:0] filt_cnt_r [2];
    logic match_r;
    logic [1:0] raw_r;
    logic [4:0] pulse_cnt_r [2];

    logic [NPIN-1:0] is_out;
    logic [NPIN-1:0] drive_val;
    logic [1:0] ts_in;
    logic [1:0] ts_act;
    logic [1:0] cap_evt;
    logic cmp_evt;
    logic tgt_clr;
    logic [31:0] rd_nxt;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    function automatic logic wr_to(input logic [7:0] r);
        wr_to = reg_wr_in && hit(reg_addr_in, r);
    endfunction : wr_to

    // Straps are caught on the first edge after release, never under reset
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            led_en_r <= 8'h00;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            led_en_r <= indicator_enable_straps_in;
            strap_done_r <= 1'b1;
        end else if (wr_to(gcwtp_pkg::ADDR_LED_CFG)) begin
            led_en_r <= reg_wdata_in[7:0];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_data_bits_r <= gcwtp_pkg::RST_ZERO12;
            pin_direction_bits_r <= gcwtp_pkg::RST_ZERO12;
        end else if (wr_to(gcwtp_pkg::ADDR_DATA_DIR)) begin
            pin_data_bits_r <= reg_wdata_in[NPIN-1:0];
            pin_direction_bits_r <=
                reg_wdata_in[gcwtp_pkg::DIR_POS +: NPIN];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            output_buffer_type_bits_r <= gcwtp_pkg::RST_ZERO12;
            ts_oe_r <= 2'h0;
            tgt_clr_en_r <= 2'h0;
            compare_polarity_r <= 2'h0;
            interrupt_polarity_bits_r <= gcwtp_pkg::RST_ZERO12;
        end else begin
            if (wr_to(gcwtp_pkg::ADDR_CFG)) begin
                output_buffer_type_bits_r <= reg_wdata_in[NPIN-1:0];
                ts_oe_r <= reg_wdata_in[gcwtp_pkg::TSOE_POS +: 2];
                tgt_clr_en_r <= reg_wdata_in[gcwtp_pkg::TCLR_POS +: 2];
                compare_polarity_r <= reg_wdata_in[gcwtp_pkg::CPOL_POS +: 2];
            end
            if (wr_to(gcwtp_pkg::ADDR_INT_POL)) begin
                interrupt_polarity_bits_r <= reg_wdata_in[NPIN-1:0];
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            event_sel_r[0] <= gcwtp_pkg::GCWTP_EV_PULSE;
            event_sel_r[1] <= gcwtp_pkg::GCWTP_EV_PULSE;
            ts_en_r <= 3'h0;
            pin_int_en_r <= gcwtp_pkg::RST_ZERO12;
            target_r <= gcwtp_pkg::RST_ZERO64;
        end else begin
            if (wr_to(gcwtp_pkg::ADDR_TS_CFG)) begin
                event_sel_r[0] <= reg_wdata_in[1:0];
                event_sel_r[1] <= reg_wdata_in[3:2];
            end
            if (wr_to(gcwtp_pkg::ADDR_TS_INT)) begin
                ts_en_r <= reg_wdata_in[gcwtp_pkg::EN_POS +: 3];
            end
            if (wr_to(gcwtp_pkg::ADDR_PIN_INT)) begin
                pin_int_en_r <= reg_wdata_in[gcwtp_pkg::EN_POS +: NPIN];
            end
            if (wr_to(gcwtp_pkg::ADDR_TGT_LO)) begin
                target_r[31:0] <= reg_wdata_in;
            end
            if (wr_to(gcwtp_pkg::ADDR_TGT_HI)) begin
                target_r[63:32] <= reg_wdata_in;
            end
        end
    end

    // Two-flop synchroniser; only sync2_r feeds logic
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_r <= gcwtp_pkg::RST_ZERO12;
            sync2_r <= gcwtp_pkg::RST_ZERO12;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    always_comb begin
        is_out = pin_direction_bits_r;
        is_out[9:8] = pin_direction_bits_r[9:8] | ts_oe_r;
        drive_val = pin_data_bits_r;
        for (int k = 0; k < 2; k++) begin
            // Active level of the timestamp pins follows their interrupt
            // polarity; compare outputs use the event polarity bits
            ts_in[k] = !is_out[8+k];
            ts_act[k] = ts_in[k] &&
                (sync2_r[8+k] == interrupt_polarity_bits_r[8+k]);
            cap_evt[k] = ts_act[k] &&
                (filt_cnt_r[k] == 4'(gcwtp_pkg::FILT_CYC - 1));
            if (ts_oe_r[k]) begin
                drive_val[8+k] = raw_r[k] ~^ compare_polarity_r[k];
            end
        end
        cmp_evt = (time_value_in == target_r) && !match_r;
        tgt_clr = |(cap_evt & tgt_clr_en_r);
    end

    // Width filter: an edge counts only once held past the least width
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            filt_cnt_r[0] <= 4'h0;
            filt_cnt_r[1] <= 4'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (!ts_act[k]) begin
                    filt_cnt_r[k] <= 4'h0;
                end else if (filt_cnt_r[k] !=
                             4'(gcwtp_pkg::FILT_CYC)) begin
                    filt_cnt_r[k] <= filt_cnt_r[k] + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            capture_r[0] <= gcwtp_pkg::RST_ZERO64;
            capture_r[1] <= gcwtp_pkg::RST_ZERO64;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (cap_evt[k]) begin
                    capture_r[k] <= time_value_in;
                end
            end
        end
    end

    // Match held so an equal time that lingers fires only once
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            match_r <= 1'b0;
        end else begin
            match_r <= (time_value_in == target_r);
        end
    end

    // Set beats both software clear and the pin clear in the same cycle
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ts_flags_r <= 3'h0;
        end else begin
            for (int b = 0; b < 3; b++) begin
                if (wr_to(gcwtp_pkg::ADDR_TS_INT) && reg_wdata_in[b]) begin
                    ts_flags_r[b] <= 1'b0;
                end
            end
            if (tgt_clr) begin
                ts_flags_r[gcwtp_pkg::TS_TGT] <= 1'b0;
            end
            if (cmp_evt) begin
                ts_flags_r[gcwtp_pkg::TS_TGT] <= 1'b1;
            end
            if (cap_evt[0]) begin
                ts_flags_r[gcwtp_pkg::TS_CAP8] <= 1'b1;
            end
            if (cap_evt[1]) begin
                ts_flags_r[gcwtp_pkg::TS_CAP9] <= 1'b1;
            end
        end
    end

    // Level interrupts re-assert while the level stays; indicator pins
    // have their input disabled and never raise status
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_top_interrupt_status_r <= gcwtp_pkg::RST_ZERO12;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (wr_to(gcwtp_pkg::ADDR_PIN_INT) && reg_wdata_in[i]) begin
                    pin_top_interrupt_status_r[i] <= 1'b0;
                end
                if ((sync2_r[i] == interrupt_polarity_bits_r[i]) &&
                    !(i < 8 && led_en_r[i % 8])) begin
                    pin_top_interrupt_status_r[i] <= 1'b1;
                end
                if (i >= 8 && cap_evt[i % 2]) begin
                    pin_top_interrupt_status_r[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            raw_r <= 2'h0;
            pulse_cnt_r[0] <= 5'h0;
            pulse_cnt_r[1] <= 5'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                case (event_sel_r[k])
                    gcwtp_pkg::GCWTP_EV_PULSE: begin
                        if (cmp_evt) begin
                            raw_r[k] <= 1'b1;
                            pulse_cnt_r[k] <= 5'(gcwtp_pkg::PULSE_CYC - 1);
                        end else if (pulse_cnt_r[k] != 5'h0) begin
                            pulse_cnt_r[k] <= pulse_cnt_r[k] - 5'h1;
                        end else begin
                            raw_r[k] <= 1'b0;
                        end
                    end
                    gcwtp_pkg::GCWTP_EV_TOGGLE: begin
                        raw_r[k] <= raw_r[k] ^ cmp_evt;
                    end
                    gcwtp_pkg::GCWTP_EV_MIRROR: begin
                        raw_r[k] <= ts_flags_r[gcwtp_pkg::TS_TGT];
                    end
                    default: begin
                        raw_r[k] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Pin drivers registered so every pin output comes from a flop
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_out <= gcwtp_pkg::RST_ZERO12;
            pin_oe_out <= gcwtp_pkg::RST_ZERO12;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (i < 8 && led_en_r[i % 8]) begin
                    pin_out[i] <= 1'b0;
                    pin_oe_out[i] <= !indicator_level_in[i % 8];
                end else if (!is_out[i]) begin
                    pin_out[i] <= 1'b0;
                    pin_oe_out[i] <= 1'b0;
                end else if (output_buffer_type_bits_r[i]) begin
                    pin_out[i] <= drive_val[i];
                    pin_oe_out[i] <= 1'b1;
                end else begin
                    pin_out[i] <= 1'b0;
                    pin_oe_out[i] <= !drive_val[i];
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_irq_out <= 1'b0;
            timestamp_event_summary_out <= 1'b0;
        end else begin
            pin_irq_out <= |(pin_top_interrupt_status_r & pin_int_en_r);
            timestamp_event_summary_out <= |(ts_flags_r & ts_en_r);
        end
    end

    always_comb begin
        rd_nxt = 32'h0;
        if (hit(reg_addr_in, gcwtp_pkg::ADDR_DATA_DIR)) begin
            for (int i = 0; i < NPIN; i++) begin
                rd_nxt[i] = is_out[i] ? pin_data_bits_r[i] : sync2_r[i];
            end
            rd_nxt[gcwtp_pkg::DIR_POS +: NPIN] = pin_direction_bits_r;
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_CFG)) begin
            rd_nxt[NPIN-1:0] = output_buffer_type_bits_r;
            rd_nxt[gcwtp_pkg::TSOE_POS +: 2] = ts_oe_r;
            rd_nxt[gcwtp_pkg::TCLR_POS +: 2] = tgt_clr_en_r;
            rd_nxt[gcwtp_pkg::CPOL_POS +: 2] = compare_polarity_r;
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_INT_POL)) begin
            rd_nxt[NPIN-1:0] = interrupt_polarity_bits_r;
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_PIN_INT)) begin
            rd_nxt[NPIN-1:0] = pin_top_interrupt_status_r;
            rd_nxt[gcwtp_pkg::EN_POS +: NPIN] = pin_int_en_r;
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_TS_INT)) begin
            rd_nxt[2:0] = ts_flags_r;
            rd_nxt[gcwtp_pkg::EN_POS +: 3] = ts_en_r;
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_TS_CFG)) begin
            rd_nxt[3:0] = {event_sel_r[1], event_sel_r[0]};
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_TGT_LO)) begin
            rd_nxt = target_r[31:0];
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_TGT_HI)) begin
            rd_nxt = target_r[63:32];
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_CAP8_LO)) begin
            rd_nxt = capture_r[0][31:0];
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_CAP8_HI)) begin
            rd_nxt = capture_r[0][63:32];
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_CAP9_LO)) begin
            rd_nxt = capture_r[1][31:0];
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_CAP9_HI)) begin
            rd_nxt = capture_r[1][63:32];
        end else if (hit(reg_addr_in, gcwtp_pkg::ADDR_LED_CFG)) begin
            rd_nxt[7:0] = led_en_r;
        end
    end

    // Read data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_nxt : 32'h0;
        end
    end

    chk_reset_dir: assert property (@(posedge clock_in)
        $rose(rst_n_in) |-> pin_direction_bits_r == 12'h000)
        else $error("direction bits not cleared by reset");
    chk_reset_intcfg: assert property (@(posedge clock_in)
        $rose(rst_n_in) |-> (pin_int_en_r == 12'h000 &&
                             interrupt_polarity_bits_r == 12'h000))
        else $error("interrupt enable or polarity not cleared");
    chk_od_drive: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        (pin_direction_bits_r[11] && !output_buffer_type_bits_r[11]) |=>
        (pin_out[11] == 1'b0 && pin_oe_out[11] == !$past(pin_data_bits_r[11])))
        else $error("open-drain pin drive wrong");
    chk_pp_drive: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        (pin_direction_bits_r[10] && output_buffer_type_bits_r[10]) |=>
        (pin_oe_out[10] && pin_out[10] == $past(pin_data_bits_r[10])))
        else $error("push-pull pin drive wrong");
    chk_capture_time: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        cap_evt[0] |=> (capture_r[0] == $past(time_value_in) &&
                        ts_flags_r[1] && pin_top_interrupt_status_r[8]))
        else $error("capture did not store time or flags");
    chk_filter_width: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        cap_evt[1] |-> ($past(ts_act[1], 10) && $past(ts_act[1], 5)))
        else $error("capture accepted a short input");
    chk_target_flag: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        cmp_evt |=> ts_flags_r[0])
        else $error("target compare did not set flag");
    chk_pulse_len: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        (cmp_evt && event_sel_r[0] == gcwtp_pkg::GCWTP_EV_PULSE) |=>
        raw_r[0] [*8])
        else $error("compare pulse too short");
    chk_pin_irq: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        ##1 pin_irq_out == $past(|(pin_top_interrupt_status_r & pin_int_en_r)))
        else $error("pin interrupt line mismatch");
    chk_sticky_sts: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        (pin_top_interrupt_status_r[3] && !wr_to(gcwtp_pkg::ADDR_PIN_INT)) |=>
        pin_top_interrupt_status_r[3])
        else $error("pin status dropped without clear");
    chk_target_clear: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        (tgt_clr && !cmp_evt) |=> !ts_flags_r[0])
        else $error("input edge did not clear target flag");
endmodule : gcwtp_top

// ===== verification/gcwtp_board.sv
// Purpose: Board model of the twelve pins: device drive, far driver, pull-up
// Assumes: Every pin carries a pull-up on the board
// Notes: Device drive wins; a released line never keeps its last level
`timescale 1ns/100ps
module gcwtp_board (
    input wire logic [11:0] pin_out_in,
    input wire logic [11:0] pin_oe_in,
    input wire logic [11:0] ext_val_in,
    input wire logic [11:0] ext_en_in,
    output logic [11:0] level_out
);
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (pin_oe_in[i]) begin
                level_out[i] = pin_out_in[i];
            end else if (ext_en_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else begin
                level_out[i] = 1'b1;
            end
        end
    end
endmodule : gcwtp_board

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the I/O controller with timestamp pins
// Assumes: Straps low, so all twelve pins start as plain I/O
// Notes: Time value counts one per system clock
`timescale 1ns/100ps
module testbench;
    logic clk, rst_n, wr_s, rd_s, irq, tse;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, q, lfsr;
    logic [11:0] p_in, p_out, p_oe, ext_val, ext_en, r, pol;
    logic [63:0] tv, t0;
    int err_count, samples_checked, n;
    gcwtp_top gcwtp_top_i (.clock_in(clk), .rst_n_in(rst_n),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s), .reg_rdata_out(rdata), .pin_in(p_in),
        .pin_out(p_out), .pin_oe_out(p_oe),
        .time_value_in(tv), .indicator_enable_straps_in(8'h00),
        .indicator_level_in(8'hff), .pin_irq_out(irq),
        .timestamp_event_summary_out(tse));
    gcwtp_board gcwtp_board_i (.pin_out_in(p_out), .pin_oe_in(p_oe),
        .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(p_in));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) tv <= tv + 64'h1;
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    // Open-drain pins only drive while their data bit is low
    function automatic logic [11:0] exp_oe(input logic [11:0] b, dd);
        return b | ~dd;
    endfunction : exp_oe
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 q = rdata;
    endtask : rd
    task automatic chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic stop_test;
        $display("checked=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        #100000;
        err_count++;
        stop_test;
    end
    initial begin
        {rst_n, wr_s, rd_s, addr, wdata, tv, ext_val} = '0;
        ext_en = 12'h000;
        lfsr = 32'he4bece43;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        rd(gcwtp_pkg::ADDR_DATA_DIR);
        chk({20'h0, q[27:16]}, 32'h0);
        rd(gcwtp_pkg::ADDR_PIN_INT);
        chk({20'h0, q[27:16]}, 32'h0);
        rd(gcwtp_pkg::ADDR_INT_POL);
        chk(q, 32'h0);
        rd(8'hfc);
        chk(q, 32'h0);
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            r = lfsr[11:0];
            wr(gcwtp_pkg::ADDR_DATA_DIR, {16'h0fff, 4'h0, r});
            wr(gcwtp_pkg::ADDR_CFG, {20'h0, lfsr[27:16]});
            cyc(3);
            chk({20'h0, p_oe}, {20'h0, exp_oe(lfsr[27:16], r)});
            chk({20'h0, p_out & p_oe}, {20'h0, r & p_oe});
        end
        $display("output test done");
        wr(gcwtp_pkg::ADDR_DATA_DIR, 32'h0);
        wr(gcwtp_pkg::ADDR_CFG, 32'h0000_3300);
        cyc(3);
        chk({30'h0, p_oe[9:8]}, 32'h3);
        // Idle compare output is high, so open-drain pins float
        wr(gcwtp_pkg::ADDR_CFG, 32'h0000_3000);
        cyc(3);
        chk({30'h0, p_oe[9:8]}, 32'h0);
        wr(gcwtp_pkg::ADDR_CFG, 32'h0);
        ext_en <= 12'hfff;
        for (int k = 0; k < 3; k++) begin
            lfsr = nxt(lfsr);
            r = lfsr[11:0];
            pol = lfsr[23:12];
            ext_val <= r;
            wr(gcwtp_pkg::ADDR_INT_POL, {20'h0, pol});
            cyc(4);
            rd(gcwtp_pkg::ADDR_DATA_DIR);
            chk({20'h0, q[11:0]}, {20'h0, r});
            wr(gcwtp_pkg::ADDR_PIN_INT, 32'h0fff_0fff);
            cyc(5);
            rd(gcwtp_pkg::ADDR_PIN_INT);
            chk({20'h0, q[11:0]}, {20'h0, ~(r ^ pol)});
            chk({31'h0, irq}, {31'h0, |(~(r ^ pol))});
            wr(gcwtp_pkg::ADDR_PIN_INT, 32'h0);
            cyc(3);
            chk({31'h0, irq}, 32'h0);
        end
        $display("interrupt test done");
        ext_val <= 12'h000;
        wr(gcwtp_pkg::ADDR_CFG, 32'h0003_3300);
        wr(gcwtp_pkg::ADDR_TS_CFG, 32'h4);
        wr(gcwtp_pkg::ADDR_TS_INT, 32'h0001_0007);
        wr(gcwtp_pkg::ADDR_TGT_HI, tv[63:32]);
        wr(gcwtp_pkg::ADDR_TGT_LO, tv[31:0] + 32'd60);
        n = 0;
        repeat (120) begin
            cyc(1);
            n += int'(p_out[8] === 1'b1);
        end
        chk(n, gcwtp_pkg::PULSE_CYC);
        chk({31'h0, p_out[9]}, 32'h1);
        chk({31'h0, tse}, 32'h1);
        wr(gcwtp_pkg::ADDR_TS_CFG, 32'h8);
        cyc(3);
        chk({31'h0, p_out[9]}, 32'h1);
        wr(gcwtp_pkg::ADDR_TS_INT, 32'h0001_0001);
        cyc(3);
        chk({30'h0, p_out[9], tse}, 32'h0);
        wr(gcwtp_pkg::ADDR_CFG, 32'h0001_3300);
        cyc(3);
        chk({31'h0, p_out[9]}, 32'h1);
        wr(gcwtp_pkg::ADDR_TGT_LO, tv[31:0] + 32'd30);
        cyc(50);
        chk({30'h0, p_out[9], tse}, 32'h1);
        $display("compare test done");
        wr(gcwtp_pkg::ADDR_CFG, 32'h0000_8300);
        // Pin 8 idles low, so it is made active high to stay quiet
        wr(gcwtp_pkg::ADDR_INT_POL, 32'h300);
        cyc(4);
        ext_val[9] <= 1'b1;
        cyc(8);
        ext_val[9] <= 1'b0;
        cyc(20);
        rd(gcwtp_pkg::ADDR_TS_INT);
        chk({29'h0, q[2:0]}, 32'h1);
        wr(gcwtp_pkg::ADDR_PIN_INT, 32'h0000_0200);
        cyc(1);
        t0 = tv;
        ext_val[9] <= 1'b1;
        cyc(12);
        ext_val[9] <= 1'b0;
        cyc(20);
        rd(gcwtp_pkg::ADDR_TS_INT);
        chk({29'h0, q[2:0]}, 32'h4);
        rd(gcwtp_pkg::ADDR_CAP9_LO);
        chk({31'h0, q > t0[31:0] && q < t0[31:0] + 32'd20}, 32'h1);
        rd(gcwtp_pkg::ADDR_PIN_INT);
        chk({31'h0, q[9]}, 32'h1);
        $display("capture test done");
        stop_test;
    end
endmodule : testbench
